/* File: common/stk_cfg.svh */
// Constants of the serial timekeeper: register map, command fields, limits and timing
`ifndef STK_CFG_SVH
`define STK_CFG_SVH

`define STK_REG_SEC      3'h0
`define STK_REG_MIN      3'h1
`define STK_REG_HOUR     3'h2
`define STK_REG_DATE     3'h3
`define STK_REG_MONTH    3'h4
`define STK_REG_DAY      3'h5
`define STK_REG_YEAR     3'h6
`define STK_REG_LOCK     3'h7

`define STK_HALT_BIT     7
`define STK_LOCK_BIT     7
`define STK_H12_BIT      7
`define STK_PM_BIT       5

`define STK_BANK_RST     64'h8000010101000080
`define STK_BANK_MASK    64'h80FF071F3FBF7FFF

`define STK_CMD_VALID    7
`define STK_CMD_DIR      0
`define STK_CMD_TEST_F   7:4
`define STK_CMD_TEST     4'h9
`define STK_CMD_BURST_F  6:1
`define STK_CMD_BURST    6'h1F
`define STK_CMD_SINGLE_F 6:4
`define STK_CMD_SINGLE   3'h0
`define STK_CMD_ADDR_F   3:1
`define STK_LAST_BIT     3'h7

`define STK_SEC_MAX      8'h59
`define STK_MIN_MAX      8'h59
`define STK_H24_MAX      8'h23
`define STK_H12_MIN      8'h01
`define STK_H12_MAX      8'h12
`define STK_H12_PRE      5'h11
`define STK_DATE_MIN     8'h01
`define STK_FEB          8'h02
`define STK_FEB_DAYS     8'h28
`define STK_LEAP_DAYS    8'h29
`define STK_SHORT_DAYS   8'h30
`define STK_LONG_DAYS    8'h31
`define STK_MONTH_MAX    8'h12
`define STK_DAY_MAX      8'h07
`define STK_YEAR_MAX     8'h99

`define STK_FIFO_DEPTH   8
`define STK_SINGLE_CLKS  16
`define STK_BURST_CLKS   72
`define STK_CLK_NS       5
`define STK_SEC_NS       1000000000
`define STK_SEC_CYCLES   (`STK_SEC_NS / `STK_CLK_NS)

`endif

/* File: common/stk_pkg.sv */
// Shared types of the serial timekeeper
`default_nettype none
package stk_pkg;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_CMD  = 6'h02,
      ST_WR   = 6'h04,
      ST_RD   = 6'h08,
      ST_SKIP = 6'h10,
      ST_TEST = 6'h20
   } stk_state_t;

   typedef struct packed {
      logic       burst;
      logic [2:0] addr;
      logic [7:0] data;
   } stk_wreq_t;

   typedef logic [7:0][7:0] stk_bank_t;
endpackage
`default_nettype wire

/* File: hw/stk_calendar.sv */
// Next-second value of the BCD clock/calendar bank
`timescale 1ns/1ps
`default_nettype none
`include "stk_cfg.svh"
module stk_calendar (
   input  wire stk_pkg::stk_bank_t cur,
   output var  stk_pkg::stk_bank_t nxt
);
   logic [8:0] s;
   logic [8:0] m;
   logic [8:0] h;
   logic [8:0] d;
   logic [8:0] mo;
   logic [8:0] dy;
   logic [8:0] y;
   logic       h12;
   logic       pm;
   logic       day_wrap;
   logic       leap;
   logic [7:0] dmax;

   // Carry in bit 8, wraps from hi to lo
   function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
      logic [8:0] r;
      if (v >= hi)
         r = {1'b1, lo};
      else if (v[3:0] >= 4'h9)
         r = {1'b0, v[7:4] + 4'h1, 4'h0};
      else
         r = {1'b0, v[7:4], v[3:0] + 4'h1};
      return r;
   endfunction

   always_comb begin
      nxt  = cur;
      h12  = cur[`STK_REG_HOUR][`STK_H12_BIT];
      pm   = cur[`STK_REG_HOUR][`STK_PM_BIT];
      leap = cur[`STK_REG_YEAR][4] ?
             (cur[`STK_REG_YEAR][3:0] == 4'h2 || cur[`STK_REG_YEAR][3:0] == 4'h6) :
             (cur[`STK_REG_YEAR][3:0] == 4'h0 || cur[`STK_REG_YEAR][3:0] == 4'h4 ||
              cur[`STK_REG_YEAR][3:0] == 4'h8);
      if (cur[`STK_REG_MONTH] == `STK_FEB)
         dmax = leap ? `STK_LEAP_DAYS : `STK_FEB_DAYS;
      else if (cur[`STK_REG_MONTH] == 8'h04 || cur[`STK_REG_MONTH] == 8'h06 ||
               cur[`STK_REG_MONTH] == 8'h09 || cur[`STK_REG_MONTH] == 8'h11)
         dmax = `STK_SHORT_DAYS;
      else
         dmax = `STK_LONG_DAYS;
      s  = bcd_inc({1'b0, cur[`STK_REG_SEC][6:0]}, 8'h00, `STK_SEC_MAX);
      m  = bcd_inc(cur[`STK_REG_MIN], 8'h00, `STK_MIN_MAX);
      if (h12)
         h = bcd_inc({3'h0, cur[`STK_REG_HOUR][4:0]}, `STK_H12_MIN, `STK_H12_MAX);
      else
         h = bcd_inc({2'h0, cur[`STK_REG_HOUR][5:0]}, 8'h00, `STK_H24_MAX);
      day_wrap = h12 ? (cur[`STK_REG_HOUR][4:0] == `STK_H12_PRE && pm) : h[8];
      d  = bcd_inc(cur[`STK_REG_DATE], `STK_DATE_MIN, dmax);
      mo = bcd_inc(cur[`STK_REG_MONTH], `STK_DATE_MIN, `STK_MONTH_MAX);
      y  = bcd_inc(cur[`STK_REG_YEAR], 8'h00, `STK_YEAR_MAX);
      dy = bcd_inc(cur[`STK_REG_DAY], `STK_DATE_MIN, `STK_DAY_MAX);
      nxt[`STK_REG_SEC] = {cur[`STK_REG_SEC][`STK_HALT_BIT], s[6:0]};
      if (s[8]) begin
         nxt[`STK_REG_MIN] = m[7:0];
         if (m[8]) begin
            // PM flips entering twelve o'clock
            if (h12)
               nxt[`STK_REG_HOUR] = {2'h2, pm ^ (cur[`STK_REG_HOUR][4:0] == `STK_H12_PRE),
                                     h[4:0]};
            else
               nxt[`STK_REG_HOUR] = {2'h0, h[5:0]};
            if (day_wrap) begin
               nxt[`STK_REG_DAY]  = dy[7:0];
               nxt[`STK_REG_DATE] = d[7:0];
               if (d[8]) begin
                  nxt[`STK_REG_MONTH] = mo[7:0];
                  if (mo[8])
                     nxt[`STK_REG_YEAR] = y[7:0];
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: hw/stk_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module stk_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign in_ready  = cnt_q != (AW + 1)'(DEPTH);
   assign out_valid = cnt_q != '0;
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Depth is a power of two, pointers wrap naturally
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push)
            wr_q <= wr_q + 1'b1;
         if (pop)
            rd_q <= rd_q + 1'b1;
         if (push && !pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop && !push)
            cnt_q <= cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (push)
         mem_q[wr_q] <= in_data;
   end
endmodule
`default_nettype wire

/* File: hw/stk_top.sv */
// Serial timekeeper: pin synchronisers, command engine, write FIFO and register bank
`timescale 1ns/1ps
`default_nettype none
`include "stk_cfg.svh"
module stk_top #(
   parameter int unsigned SEC_CYCLES = `STK_SEC_CYCLES
) (
   input  wire logic CLK_SYS,
   input  wire logic RSTN,
   input  wire logic TRANSFER_ENABLE_N,
   input  wire logic SERIAL_CLK,
   input  wire logic DATA_I,
   output logic      DATA_O,
   output logic      DATA_OE
);
   localparam stk_pkg::stk_bank_t BANK_MASK = `STK_BANK_MASK;
   localparam int                 SEC_W     = $clog2(SEC_CYCLES) + 1;

   logic                  rst_meta_q;
   logic                  rst_n_q;
   logic [2:0]            pin_meta_q;
   logic [2:0]            pin_q;
   logic                  sclk_prev_q;
   logic                  te_s;
   logic                  din_s;
   logic                  rise;
   logic                  fall;

   stk_pkg::stk_state_t   state_q;
   logic [2:0]            bit_q;
   logic [2:0]            addr_q;
   logic                  burst_q;
   logic [7:0]            cmd_q;
   logic [7:0]            cmd_next;
   logic                  cmd_burst;
   logic                  cmd_single;
   logic [7:0]            wsh_q;
   logic [7:0]            rsh_q;
   logic                  rd_bit;
   logic                  first_bit;

   logic                  push_now;
   logic                  wr_push_q;
   stk_pkg::stk_wreq_t    wr_req_q;
   logic                  fifo_in_ready;
   stk_pkg::stk_wreq_t    fifo_out;
   logic                  fifo_out_valid;
   logic                  drain_ready;
   logic                  drain_fire;
   logic [7:0]            wr_masked;
   logic                  locked;

   stk_pkg::stk_bank_t    regs_q;
   stk_pkg::stk_bank_t    cal_next;
   logic [SEC_W-1:0]      sec_cnt_q;
   logic                  tick_q;

   logic                  data_o_q;
   logic                  data_oe_q;
   logic [6:0]            rise_cnt_q;

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!rst_n_q);

   // Reset release through two flip-flops
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // Pin synchronisers and serial clock edge history
   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pin_meta_q  <= 3'h0;
         pin_q       <= 3'h0;
         sclk_prev_q <= 1'b0;
      end else begin
         pin_meta_q  <= {DATA_I, SERIAL_CLK, TRANSFER_ENABLE_N};
         pin_q       <= pin_meta_q;
         sclk_prev_q <= pin_q[1];
      end
   end

   assign te_s       = pin_q[0];
   assign din_s      = pin_q[2];
   assign rise       = pin_q[1] && !sclk_prev_q;
   assign fall       = !pin_q[1] && sclk_prev_q;
   assign cmd_next   = {din_s, cmd_q[7:1]};
   assign cmd_burst  = cmd_next[`STK_CMD_VALID] && cmd_next[`STK_CMD_BURST_F] == `STK_CMD_BURST;
   assign cmd_single = cmd_next[`STK_CMD_VALID] &&
                       cmd_next[`STK_CMD_SINGLE_F] == `STK_CMD_SINGLE;
   assign rd_bit     = (bit_q == 3'h0) ? regs_q[addr_q][0] : rsh_q[0];
   assign first_bit  = regs_q[addr_q][0];
   assign locked     = regs_q[`STK_REG_LOCK][`STK_LOCK_BIT];

   // Command engine
   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= stk_pkg::ST_IDLE;
         bit_q   <= 3'h0;
         addr_q  <= 3'h0;
         burst_q <= 1'b0;
         cmd_q   <= 8'h00;
         wsh_q   <= 8'h00;
         rsh_q   <= 8'h00;
      end else if (!te_s) begin
         state_q <= stk_pkg::ST_IDLE;
         bit_q   <= 3'h0;
      end else begin
         unique case (state_q)
            stk_pkg::ST_IDLE: begin
               state_q <= stk_pkg::ST_CMD;
               cmd_q   <= 8'h00;
            end
            stk_pkg::ST_CMD: begin
               if (rise) begin
                  cmd_q <= cmd_next;
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == `STK_LAST_BIT) begin
                     if (!cmd_next[`STK_CMD_VALID]) begin
                        state_q <= stk_pkg::ST_SKIP;
                     end else if (cmd_next[`STK_CMD_TEST_F] == `STK_CMD_TEST &&
                                  cmd_next[`STK_CMD_DIR]) begin
                        // Test pattern parks the engine until the frame ends
                        state_q <= stk_pkg::ST_TEST;
                     end else if (cmd_burst) begin
                        burst_q <= 1'b1;
                        addr_q  <= `STK_REG_SEC;
                        state_q <= cmd_next[`STK_CMD_DIR] ? stk_pkg::ST_RD : stk_pkg::ST_WR;
                     end else if (cmd_single) begin
                        burst_q <= 1'b0;
                        addr_q  <= cmd_next[`STK_CMD_ADDR_F];
                        state_q <= cmd_next[`STK_CMD_DIR] ? stk_pkg::ST_RD : stk_pkg::ST_WR;
                     end else begin
                        state_q <= stk_pkg::ST_SKIP;
                     end
                  end
               end
            end
            stk_pkg::ST_WR: begin
               if (rise) begin
                  wsh_q <= {din_s, wsh_q[7:1]};
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == `STK_LAST_BIT) begin
                     if (burst_q && addr_q != `STK_REG_LOCK)
                        addr_q <= addr_q + 3'h1;
                     else
                        state_q <= stk_pkg::ST_SKIP;
                  end
               end
            end
            stk_pkg::ST_RD: begin
               if (fall) begin
                  // Byte latched at its first bit so a tick cannot tear it
                  rsh_q <= (bit_q == 3'h0) ? {1'b0, regs_q[addr_q][7:1]} : {1'b0, rsh_q[7:1]};
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == `STK_LAST_BIT && burst_q)
                     addr_q <= addr_q + 3'h1;
               end
            end
            stk_pkg::ST_SKIP, stk_pkg::ST_TEST: begin
            end
         endcase
      end
   end

   // Completed write byte waits here until the FIFO takes it
   assign push_now = te_s && state_q == stk_pkg::ST_WR && rise && bit_q == `STK_LAST_BIT;

   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wr_push_q <= 1'b0;
         wr_req_q  <= '0;
      end else if (push_now) begin
         wr_push_q      <= 1'b1;
         wr_req_q.burst <= burst_q;
         wr_req_q.addr  <= addr_q;
         wr_req_q.data  <= {din_s, wsh_q[7:1]};
      end else if (fifo_in_ready) begin
         wr_push_q <= 1'b0;
      end
   end

   stk_fifo #(
      .WIDTH ($bits(stk_pkg::stk_wreq_t)),
      .DEPTH (`STK_FIFO_DEPTH)
   ) u_fifo (
      .clk       (CLK_SYS),
      .rst_n     (rst_n_q),
      .in_data   (wr_req_q),
      .in_valid  (wr_push_q),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out),
      .out_valid (fifo_out_valid),
      .out_ready (drain_ready)
   );

   // Calendar update owns the bank in its cycle, writes stall behind it
   assign drain_ready = !tick_q;
   assign drain_fire  = fifo_out_valid && drain_ready;
   assign wr_masked   = fifo_out.data & BANK_MASK[fifo_out.addr];

   stk_calendar u_cal (
      .cur (regs_q),
      .nxt (cal_next)
   );

   // One-second divider, held clear while halted
   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sec_cnt_q <= '0;
         tick_q    <= 1'b0;
      end else if (regs_q[`STK_REG_SEC][`STK_HALT_BIT]) begin
         sec_cnt_q <= '0;
         tick_q    <= 1'b0;
      end else if (sec_cnt_q == SEC_W'(SEC_CYCLES - 1)) begin
         sec_cnt_q <= '0;
         tick_q    <= 1'b1;
      end else begin
         sec_cnt_q <= sec_cnt_q + 1'b1;
         tick_q    <= 1'b0;
      end
   end

   // Register bank
   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         regs_q <= `STK_BANK_RST;
      end else if (tick_q) begin
         regs_q <= cal_next;
      end else if (drain_fire) begin
         if (fifo_out.addr == `STK_REG_LOCK) begin
            if (!fifo_out.burst)
               regs_q[`STK_REG_LOCK] <= wr_masked;
         end else if (!locked) begin
            regs_q[fifo_out.addr] <= wr_masked;
         end
      end
   end

   // Data pin drive
   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         data_o_q  <= 1'b0;
         data_oe_q <= 1'b0;
      end else if (!te_s) begin
         data_oe_q <= 1'b0;
      end else if (state_q == stk_pkg::ST_RD && fall) begin
         data_o_q  <= rd_bit;
         data_oe_q <= 1'b1;
      end
   end

   assign DATA_O  = data_o_q;
   assign DATA_OE = data_oe_q;

   // Rising edges seen in the current frame
   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q)
         rise_cnt_q <= 7'h00;
      else if (!te_s)
         rise_cnt_q <= 7'h00;
      else if (rise && rise_cnt_q != 7'h7F)
         rise_cnt_q <= rise_cnt_q + 7'h01;
   end

   te_release_a: assert property (
      !te_s |=> !data_oe_q && state_q == stk_pkg::ST_IDLE)
      else $error("Engine or data pin active after enable low");

   dir_select_a: assert property (
      te_s && state_q == stk_pkg::ST_CMD && rise && bit_q == `STK_LAST_BIT &&
      (cmd_burst || cmd_single) |=>
      ($past(cmd_q[1]) ? state_q == stk_pkg::ST_RD : state_q == stk_pkg::ST_WR))
      else $error("Command direction bit not honoured");

   single_addr_a: assert property (
      te_s && state_q == stk_pkg::ST_CMD && rise && bit_q == `STK_LAST_BIT && cmd_single
      |=> addr_q == $past(cmd_q[4:2]) && !burst_q)
      else $error("Single transfer selects wrong register");

   burst_start_a: assert property (
      te_s && state_q == stk_pkg::ST_CMD && rise && bit_q == `STK_LAST_BIT && cmd_burst
      |=> addr_q == `STK_REG_SEC && burst_q && bit_q == 3'h0)
      else $error("Burst does not start at register zero bit zero");

   frame_len_a: assert property (
      push_now |-> (burst_q ? (rise_cnt_q[2:0] == 3'h7 &&
                               rise_cnt_q <= 7'(`STK_BURST_CLKS - 1)) :
                              rise_cnt_q == 7'(`STK_SINGLE_CLKS - 1)))
      else $error("Write byte completed at wrong clock count");

   write_store_a: assert property (
      drain_fire && fifo_out.addr != `STK_REG_LOCK && !locked |=>
      regs_q[$past(fifo_out.addr)] == $past(wr_masked))
      else $error("Unlocked write not stored");

   lock_blocks_a: assert property (
      drain_fire && fifo_out.addr != `STK_REG_LOCK && locked |=> regs_q == $past(regs_q))
      else $error("Locked bank changed by a write");

   burst_lock_a: assert property (
      drain_fire && fifo_out.burst |=> regs_q[`STK_REG_LOCK] == $past(regs_q[`STK_REG_LOCK]))
      else $error("Burst write changed the lock register");

   halt_stops_a: assert property (
      regs_q[`STK_REG_SEC][`STK_HALT_BIT] && $past(regs_q[`STK_REG_SEC][`STK_HALT_BIT])
      |-> !tick_q ##1 !tick_q)
      else $error("Second tick while oscillator halted");

   first_bit_a: assert property (
      te_s && state_q == stk_pkg::ST_RD && fall && bit_q == 3'h0 |=>
      data_oe_q && data_o_q == $past(first_bit))
      else $error("First read bit not driven after falling edge");

   single_repeat_a: assert property (
      te_s && state_q == stk_pkg::ST_RD && fall && bit_q == `STK_LAST_BIT && !burst_q
      |=> addr_q == $past(addr_q) && bit_q == 3'h0)
      else $error("Single read does not retransmit the same byte");

   hour12_roll_a: assert property (
      tick_q && regs_q[`STK_REG_HOUR][`STK_H12_BIT] &&
      regs_q[`STK_REG_HOUR][4:0] == `STK_H12_PRE && regs_q[`STK_REG_MIN] == `STK_MIN_MAX &&
      {1'b0, regs_q[`STK_REG_SEC][6:0]} == `STK_SEC_MAX |=>
      regs_q[`STK_REG_HOUR][`STK_H12_BIT] && {3'h0, regs_q[`STK_REG_HOUR][4:0]} == `STK_H12_MAX &&
      regs_q[`STK_REG_HOUR][`STK_PM_BIT] != $past(regs_q[`STK_REG_HOUR][`STK_PM_BIT]))
      else $error("Twelve-hour roll or meridiem flip wrong");

   hour24_roll_a: assert property (
      tick_q && !regs_q[`STK_REG_HOUR][`STK_H12_BIT] &&
      {2'h0, regs_q[`STK_REG_HOUR][5:0]} == `STK_H24_MAX &&
      regs_q[`STK_REG_MIN] == `STK_MIN_MAX &&
      {1'b0, regs_q[`STK_REG_SEC][6:0]} == `STK_SEC_MAX |=>
      regs_q[`STK_REG_HOUR] == 8'h00 && regs_q[`STK_REG_DAY] != $past(regs_q[`STK_REG_DAY]))
      else $error("Twenty-four-hour midnight roll wrong");

   sec_count_a: assert property (
      tick_q && regs_q[`STK_REG_SEC][3:0] < 4'h9 |=>
      regs_q[`STK_REG_SEC][3:0] == $past(regs_q[`STK_REG_SEC][3:0]) + 4'h1)
      else $error("Seconds did not advance on tick");
endmodule
`default_nettype wire

/* File: tb/stk_host.sv */
// Host model driving the three-wire serial link
`timescale 1ns/1ps
`default_nettype none
module stk_host (
   input  wire logic clk,
   input  wire logic pin,
   output logic      en,
   output logic      sclk,
   output logic      d,
   output logic      oe
);
   initial begin
      en = 1'h0;
      sclk = 1'h0;
      d = 1'h0;
      oe = 1'h0;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Command then nb data bits, LSB first; test commands never issued
   task automatic xfer(input logic [7:0] c, input int nb, input logic [63:0] w,
                       output logic [63:0] rd);
      rd = '0;
      en = 1'h1;
      oe = 1'h1;
      wt(16);
      for (int i = 0; i < 8 + nb; i++) begin
         sclk = 1'h0;
         oe = (i < 8) || !c[0];
         d = (i < 8) ? c[i[2:0]] : w[6'(i - 8)];
         wt(16);
         sclk = 1'h1;
         if (i >= 8) rd[6'(i - 8)] = pin;
         wt(16);
      end
      sclk = 1'h0;
      wt(8);
      en = 1'h0;
      oe = 1'h0;
      wt(16);
   endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench of the serial timekeeper
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin n_errors++; \
   $display("wrong value %s exp %h got %h", nm, e, s); end end
module tb_top;
   typedef struct {logic [7:0] c; int n; logic [63:0] w; logic [63:0] x;} stk_row_t;
   logic        CLK_SYS = 1'h0;
   logic        RSTN = 1'h0;
   logic        idle_q = 1'h0;
   logic        oe_seen = 1'h0;
   logic        en, sclk, h_d, h_oe, DATA_O, DATA_OE, pin;
   logic [63:0] rd;
   int          n_errors = 0;
   int          num_checks = 0;
   stk_row_t    rows [19] = '{
      '{8'h8F, 8, 0, 64'h80}, '{8'h81, 8, 0, 64'h80},
      '{8'h80, 8, 64'h25, 0}, '{8'h81, 8, 0, 64'h80},
      '{8'h8E, 8, 64'h00, 0}, '{8'h8F, 8, 0, 64'h00},
      '{8'h84, 8, 64'hA5, 0}, '{8'h85, 8, 0, 64'hA5},
      '{8'h84, 8, 64'h23, 0}, '{8'h85, 16, 0, 64'h2323},
      '{8'hBE, 64, 64'h8099030228123480, 0},
      '{8'hBF, 64, 0, 64'h0099030228123480},
      '{8'h8C, 4, 64'h5, 0}, '{8'h8D, 8, 0, 64'h99},
      '{8'h8E, 8, 64'h80, 0}, '{8'h82, 8, 64'h11, 0},
      '{8'h83, 8, 0, 64'h34}, '{8'h89, 8, 0, 64'h02},
      '{8'hBF, 72, 0, 64'h8099030228123480}};
   always #2.5 CLK_SYS = ~CLK_SYS;
   always @(posedge CLK_SYS) idle_q <= ~idle_q;
   always @(posedge CLK_SYS) if (DATA_OE) oe_seen <= 1'h1;
   // Released pin shows a toggling level, not the last driven bit
   assign pin = DATA_OE ? DATA_O : (h_oe ? h_d : idle_q);
   stk_host host (
      .clk  (CLK_SYS),
      .pin  (pin),
      .en   (en),
      .sclk (sclk),
      .d    (h_d),
      .oe   (h_oe)
   );
   stk_top #(.SEC_CYCLES(8000)) uut (
      .CLK_SYS           (CLK_SYS),
      .RSTN              (RSTN),
      .TRANSFER_ENABLE_N (en),
      .SERIAL_CLK        (sclk),
      .DATA_I            (pin),
      .DATA_O            (DATA_O),
      .DATA_OE           (DATA_OE)
   );
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge CLK_SYS);
      RSTN = 1'h1;
      host.wt(8);
      `CHK("oe at reset", 1'h0, DATA_OE)
      // Reset values, lock, hour modes, burst, abort, repeat reads
      foreach (rows[k]) begin
         host.xfer(rows[k].c, rows[k].n, rows[k].w, rd);
         if (rows[k].c[0]) `CHK("read", rows[k].x, rd)
      end
      `CHK("oe after frame", 1'h0, DATA_OE)
      // Timekeeping: reads land between ticks, two ticks after start
      host.xfer(8'h8E, 8, 64'h00, rd);
      host.xfer(8'hBE, 64, 64'h0099070228235959, rd);
      host.xfer(8'h8E, 8, 64'h80, rd);
      host.wt(16000);
      host.xfer(8'hBF, 64, 0, rd);
      `CHK("midnight carry", 64'h8099010301000001, rd)
      // Halt set, then more than one tick period of waiting
      host.xfer(8'h8E, 8, 64'h00, rd);
      host.xfer(8'h80, 8, 64'h80, rd);
      host.wt(10000);
      host.xfer(8'h81, 8, 0, rd);
      `CHK("halted seconds", 64'h80, rd)
      // Twelve-hour 11:59:59 AM rolls to 12 PM after one tick
      host.xfer(8'hBE, 64, 64'h0099010301915959, rd);
      host.wt(8000);
      host.xfer(8'hBF, 64, 0, rd);
      `CHK("twelve hour roll", 64'h0099010301B20000, rd)
      oe_seen = 1'h0;
      host.xfer(8'hA1, 8, 0, rd);
      `CHK("unknown read pin", 1'h0, oe_seen)
      oe_seen = 1'h0;
      host.xfer(8'h0F, 8, 0, rd);
      `CHK("bad command pin", 1'h0, oe_seen)
      complete_run();
   end
   initial begin
      repeat (90000) @(posedge CLK_SYS);
      n_errors++;
      complete_run();
   end
endmodule
`default_nettype wire
